/* File: fsrb_host_model.sv */
// Host microcontroller model driving the serial link in mode 0
`timescale 1ns/1ps
module fsrb_host_model (
  // Clock
  input wire logic clk_in,
  // Serial pins
  output logic sclk_out,
  output logic mosi_out,
  output logic select_bar_out,
  input wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    mosi_out = 1'b1;
    select_bar_out = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first; a count other than 16 makes a malformed frame
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    @(negedge clk_in);
    select_bar_out = 1'b0;
    // First bit needs the select synchroniser to settle
    repeat (6) @(negedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      mosi_out = w[15-i];
      repeat (4) @(negedge clk_in);
      r = {r[14:0], miso_in};
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    select_bar_out = 1'b1;
    // Released line shows the inverse, never a stale level
    mosi_out = ~mosi_out;
    repeat (8) @(negedge clk_in);
  endtask : xfer
endmodule : fsrb_host_model

/* File: fsrb_ol_filter.sv */
// Open-load filter delay timer restarted by chip select release
`timescale 1ns/1ps
module fsrb_ol_filter #(
  parameter int CYCLES = fsrb_pkg::OL_FILT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Control
  input wire logic restart_in,
  // Status
  output logic expired_out
);
  import fsrb_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // Timer also runs from reset so detection starts without a first frame
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
      expired_out <= 1'b0;
    end else if (restart_in) begin
      cnt_q <= '0;
      expired_out <= 1'b0;
    end else if (!expired_out) begin
      if (cnt_q == LAST) begin
        expired_out <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : fsrb_ol_filter

/* File: fsrb_pkg.sv */
// Constants, register map and types of the fault status register bank
package fsrb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame layout
  localparam int FRAME_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int FRAME_WR_BIT = 15;
  localparam int FRAME_ADDR_LSB = 8;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_DRV_BASE = 4'h7;
  localparam logic [ADDR_W-1:0] REG_O2H = 4'h7;
  localparam logic [ADDR_W-1:0] REG_IGN1 = 4'h8;
  localparam logic [ADDR_W-1:0] REG_IGN2 = 4'h9;
  localparam logic [ADDR_W-1:0] REG_WDOG = 4'ha;
  localparam logic [ADDR_W-1:0] REG_VRS = 4'hb;
  localparam logic [ADDR_W-1:0] REG_SUP = 4'hd;
  localparam logic [ADDR_W-1:0] REG_ONOFF = 4'he;
  localparam logic [ADDR_W-1:0] REG_ID = 4'hf;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int N_DRV = 3;
  localparam int BIT_SUM = 7;
  localparam int BIT_OL = 3;
  localparam int BIT_OC = 2;
  localparam int BIT_ISO_OT = 0;
  localparam int BIT_CLAMP_N = 1;
  localparam int BIT_CLAMP_P = 2;
  localparam int PEAK_LSB = 4;
  localparam int PEAK_W = 4;
  localparam int BIT_VP_GND = 0;
  localparam int BIT_VP_OT = 1;
  localparam int BIT_VP_BAT = 2;
  localparam int BIT_SPI_ERR = 3;
  localparam int BIT_BATSW = 4;
  localparam int BIT_PWREN = 5;
  localparam int BIT_KEYSW = 6;
  localparam int WD_TIMER_W = 7;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [N_DRV-1:0] PD_EN_RESET = 3'h7;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int OL_FILT_MIN_US = 100;
  localparam int OL_FILT_MAX_US = 450;
  // Least time, rounded up to whole cycles
  localparam int OL_FILT_CYC = (OL_FILT_MIN_US * (CLK_HZ / 1_000) + 999) / 1_000;

  //////////////////////////////////////////////////////////////////////////////
  // Serial slave state, Gray coded
  typedef enum logic [1:0] {
    FSRB_IDLE = 2'b00,
    FSRB_SHIFT = 2'b01
  } fsrb_spi_state_t;

endpackage : fsrb_pkg

/* File: fsrb_spi_slave.sv */
// Serial slave: pin synchronisers, 16-bit frame shifter, frame checks
`timescale 1ns/1ps
module fsrb_spi_slave (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Serial pins
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic select_bar_pin_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  // Frame side
  input wire logic [fsrb_pkg::FRAME_W-1:0] tx_word_in,
  output logic [fsrb_pkg::FRAME_W-1:0] rx_word_out,
  output logic frame_valid_out,
  output logic frame_err_out,
  output logic cs_rise_out
);
  import fsrb_pkg::*;

  logic [2:0] sclk_q;
  logic [2:0] csb_q;
  logic [1:0] mosi_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  fsrb_spi_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [FRAME_W-1:0] rx_q;
  logic [FRAME_W-1:0] tx_q;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sclk_q <= 3'h0;
      csb_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_in};
      csb_q <= {csb_q[1:0], select_bar_pin_in};
      mosi_q <= {mosi_q[0], mosi_in};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_fall = ~csb_q[1] & csb_q[2];
  assign cs_rise = csb_q[1] & ~csb_q[2];

  //////////////////////////////////////////////////////////////////////////////
  // Frame state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= FSRB_IDLE;
    end else begin
      case (state_q)
        FSRB_IDLE: if (cs_fall) state_q <= FSRB_SHIFT;
        FSRB_SHIFT: if (cs_rise) state_q <= FSRB_IDLE;
        default: state_q <= FSRB_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive shifter, mode 0: sample on rising clock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_q <= '0;
      cnt_q <= '0;
    end else if (cs_fall) begin
      cnt_q <= '0;
    end else if (state_q == FSRB_SHIFT && sclk_rise) begin
      rx_q <= {rx_q[FRAME_W-2:0], mosi_q[1]};
      if (cnt_q != CNT_MAX) cnt_q <= cnt_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit shifter, changes on falling clock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_q <= '0;
      miso_out <= 1'b0;
      miso_oe_n_out <= 1'b1;
    end else if (cs_fall) begin
      tx_q <= tx_word_in;
      miso_out <= tx_word_in[FRAME_W-1];
      miso_oe_n_out <= 1'b0;
    end else if (cs_rise) begin
      miso_oe_n_out <= 1'b1;
    end else if (state_q == FSRB_SHIFT && sclk_fall) begin
      tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
      miso_out <= tx_q[FRAME_W-2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame end: only an exact 16-bit frame is acted on
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_word_out <= '0;
      frame_valid_out <= 1'b0;
      frame_err_out <= 1'b0;
      cs_rise_out <= 1'b0;
    end else begin
      cs_rise_out <= cs_rise;
      frame_valid_out <= cs_rise && state_q == FSRB_SHIFT && cnt_q == FRAME_BITS;
      frame_err_out <= cs_rise && state_q == FSRB_SHIFT && cnt_q != FRAME_BITS;
      if (cs_rise) rx_word_out <= rx_q;
    end
  end

endmodule : fsrb_spi_slave

/* File: fsrb_top.sv */
// Fault status register bank with off-state open-load detection
`timescale 1ns/1ps
module fsrb_top #(
  parameter logic [fsrb_pkg::DATA_W-1:0] MODEL_REV_ID = 8'h00, // Value is arbitrary
  parameter int OL_FILT_CYCLES = fsrb_pkg::OL_FILT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Serial pins
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic select_bar_pin_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  // Output drivers: heater, ignition one, ignition two
  input wire logic [fsrb_pkg::N_DRV-1:0] open_load_cmp_in,
  input wire logic [fsrb_pkg::N_DRV-1:0] over_current_in,
  input wire logic [fsrb_pkg::N_DRV-1:0] drv_off_cmd_in,
  input wire logic [fsrb_pkg::N_DRV-1:0] pd_dis_cmd_in,
  input wire logic sleep_in,
  output logic [fsrb_pkg::N_DRV-1:0] pd_en_out,
  // Speed sensor and K-line conditions
  input wire logic [fsrb_pkg::PEAK_W-1:0] vrs_peak_in,
  input wire logic vrs_clamp_p_in,
  input wire logic vrs_clamp_n_in,
  input wire logic iso_over_temp_in,
  // Supply conditions
  input wire logic keysw_in,
  input wire logic pwren_in,
  input wire logic batsw_in,
  input wire logic vp_short_bat_in,
  input wire logic vp_over_temp_in,
  input wire logic vp_short_gnd_in,
  // Internal logic state
  input wire logic wd_enable_in,
  input wire logic [fsrb_pkg::WD_TIMER_W-1:0] wd_timer_in,
  input wire logic [fsrb_pkg::DATA_W-1:0] on_off_in
);
  import fsrb_pkg::*;

  localparam int SYNC_W = 2 * N_DRV + PEAK_W + 9;

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [N_DRV-1:0] ol_cmp_s;
  logic [N_DRV-1:0] oc_s;
  logic [PEAK_W-1:0] peak_s;
  logic clamp_p_s;
  logic clamp_n_s;
  logic iso_ot_s;
  logic keysw_s;
  logic pwren_s;
  logic batsw_s;
  logic vp_bat_s;
  logic vp_ot_s;
  logic vp_gnd_s;

  logic [FRAME_W-1:0] rx_word;
  logic [FRAME_W-1:0] tx_word;
  logic frame_valid;
  logic frame_err;
  logic cs_rise;
  logic filt_expired;
  logic [ADDR_W-1:0] resp_addr_q;
  logic [DATA_W-1:0] rd_data;

  logic [N_DRV-1:0] pd_en_q;
  logic [N_DRV-1:0] drv_ol_q;
  logic [N_DRV-1:0] drv_oc_q;
  logic [N_DRV-1:0] drv_sum_q;
  logic [N_DRV-1:0] ol_present;
  logic [N_DRV-1:0] ol_event;
  logic iso_ot_q;
  logic [3:0] sup_q;
  logic sys_sum_q;
  logic [3:0] sup_event;
  logic any_event;
  logic any_present;
  logic [DATA_W-1:0] vrs_clr;
  logic [DATA_W-1:0] sup_clr;

  // Bits that a write of zero asks to clear, for one register
  function automatic logic [DATA_W-1:0] clr_mask(input logic valid,
                                                 input logic [FRAME_W-1:0] word,
                                                 input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = valid && word[FRAME_WR_BIT] && word[FRAME_ADDR_LSB +: ADDR_W] == addr;
    clr_mask = hit ? ~word[DATA_W-1:0] : REG_RESET;
  endfunction : clr_mask

  //////////////////////////////////////////////////////////////////////////////
  // Pin conditions pass two flip-flops before use
  assign raw = {open_load_cmp_in, over_current_in, vrs_peak_in, vrs_clamp_p_in,
                vrs_clamp_n_in, iso_over_temp_in, keysw_in, pwren_in, batsw_in,
                vp_short_bat_in, vp_over_temp_in, vp_short_gnd_in};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  assign {ol_cmp_s, oc_s, peak_s, clamp_p_s, clamp_n_s, iso_ot_s, keysw_s, pwren_s,
          batsw_s, vp_bat_s, vp_ot_s, vp_gnd_s} = sync2_q;

  //////////////////////////////////////////////////////////////////////////////
  // Serial link and filter timer
  fsrb_spi_slave u_spi (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sclk_in(sclk_in),
    .mosi_in(mosi_in),
    .select_bar_pin_in(select_bar_pin_in),
    .miso_out(miso_out),
    .miso_oe_n_out(miso_oe_n_out),
    .tx_word_in(tx_word),
    .rx_word_out(rx_word),
    .frame_valid_out(frame_valid),
    .frame_err_out(frame_err),
    .cs_rise_out(cs_rise)
  );

  fsrb_ol_filter #(
    .CYCLES(OL_FILT_CYCLES)
  ) u_filter (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .restart_in(cs_rise),
    .expired_out(filt_expired)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pull-down sources
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pd_en_q <= PD_EN_RESET;
    end else begin
      pd_en_q <= ~(pd_dis_cmd_in | {N_DRV{sleep_in}});
    end
  end

  assign pd_en_out = pd_en_q;

  //////////////////////////////////////////////////////////////////////////////
  // Driver fault registers; only open-load and overcurrent exist here
  generate
    for (genvar i = 0; i < N_DRV; i++) begin : g_drv
      localparam logic [ADDR_W-1:0] ADDR = REG_DRV_BASE + ADDR_W'(i);
      logic [DATA_W-1:0] clr;
      assign clr = clr_mask(frame_valid, rx_word, ADDR);
      // One comparator per output, live only while commanded off
      assign ol_present[i] = ol_cmp_s[i] & drv_off_cmd_in[i] & pd_en_q[i];
      assign ol_event[i] = ol_present[i] & filt_expired;

      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          drv_ol_q[i] <= 1'b0;
          drv_oc_q[i] <= 1'b0;
          drv_sum_q[i] <= 1'b0;
        end else begin
          // Disabled pull-down forces the open-load bit low, a new event wins over a clear
          if (!pd_en_q[i]) begin
            drv_ol_q[i] <= 1'b0;
          end else if (ol_event[i]) begin
            drv_ol_q[i] <= 1'b1;
          end else if (clr[BIT_OL] && !ol_present[i]) begin
            drv_ol_q[i] <= 1'b0;
          end
          if (oc_s[i]) begin
            drv_oc_q[i] <= 1'b1;
          end else if (clr[BIT_OC]) begin
            drv_oc_q[i] <= 1'b0;
          end
          if (ol_event[i] || oc_s[i]) begin
            drv_sum_q[i] <= 1'b1;
          end else if (clr[BIT_SUM] && !ol_present[i]) begin
            drv_sum_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Sensor and supply registers
  assign vrs_clr = clr_mask(frame_valid, rx_word, REG_VRS);
  assign sup_clr = clr_mask(frame_valid, rx_word, REG_SUP);
  assign sup_event = {frame_err, vp_bat_s, vp_ot_s, vp_gnd_s};
  assign any_event = |{sup_event, iso_ot_s, ol_event, oc_s};
  assign any_present = |{vp_bat_s, vp_ot_s, vp_gnd_s, iso_ot_s, ol_present, oc_s};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      iso_ot_q <= 1'b0;
    end else if (iso_ot_s) begin
      iso_ot_q <= 1'b1;
    end else if (vrs_clr[BIT_ISO_OT]) begin
      iso_ot_q <= 1'b0;
    end
  end

  // Each supply bit clears only while its own condition is gone
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sup_q <= 4'h0;
    end else begin
      sup_q <= sup_event | (sup_q & ~(sup_clr[3:0] & ~sup_event));
    end
  end

  // System summary waits until no fault condition remains anywhere
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sys_sum_q <= 1'b0;
    end else if (any_event) begin
      sys_sum_q <= 1'b1;
    end else if (sup_clr[BIT_SUM] && !any_present) begin
      sys_sum_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read side: response carries the register addressed by the previous valid frame
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      resp_addr_q <= REG_ID;
    end else if (frame_valid) begin
      resp_addr_q <= rx_word[FRAME_ADDR_LSB +: ADDR_W];
    end
  end

  // Unused positions are constant zero and have no storage
  always_comb begin
    rd_data = REG_RESET;
    case (resp_addr_q)
      REG_O2H, REG_IGN1, REG_IGN2: begin
        for (int i = 0; i < N_DRV; i++) begin
          if (resp_addr_q == REG_DRV_BASE + ADDR_W'(i)) begin
            rd_data[BIT_SUM] = drv_sum_q[i];
            rd_data[BIT_OL] = drv_ol_q[i] & pd_en_q[i];
            rd_data[BIT_OC] = drv_oc_q[i];
          end
        end
      end
      REG_WDOG: rd_data = {wd_enable_in, wd_timer_in};
      REG_VRS: begin
        rd_data[PEAK_LSB +: PEAK_W] = peak_s;
        rd_data[BIT_CLAMP_P] = clamp_p_s;
        rd_data[BIT_CLAMP_N] = clamp_n_s;
        rd_data[BIT_ISO_OT] = iso_ot_q;
      end
      REG_SUP: begin
        rd_data[BIT_SUM] = sys_sum_q;
        rd_data[BIT_KEYSW] = keysw_s;
        rd_data[BIT_PWREN] = pwren_s;
        rd_data[BIT_BATSW] = batsw_s;
        rd_data[3:0] = sup_q;
      end
      REG_ONOFF: rd_data = on_off_in;
      REG_ID: rd_data = MODEL_REV_ID;
      default: rd_data = REG_RESET;
    endcase
  end

  assign tx_word = {4'h0, resp_addr_q, rd_data};

endmodule : fsrb_top

/* File: fsrb_top_bench.sv */
// Self-checking bench of the fault status register bank
`timescale 1ns/1ps
module fsrb_top_bench;
  import fsrb_pkg::*;
  // Short filter keeps the run brief
  localparam int FILT = 200;
  localparam logic [7:0] REV = 8'h5a; // Value is arbitrary
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sclk, mosi, select_bar_pin, miso, miso_oe_n;
  logic [2:0] ol_cmp = 3'h0, oc = 3'h0, off_cmd = 3'h0, pd_dis = 3'h0, pd_en;
  logic sleep = 1'b0, clamp_p = 1'b0, iso_ot = 1'b0, keysw = 1'b0, vp_gnd = 1'b0;
  logic wd_en = 1'b0, clamp_n = 1'b0, pwren = 1'b0, batsw = 1'b0;
  logic [3:0] peak = 4'h0;
  logic [6:0] wd_tmr = 7'h00;
  logic [7:0] on_off = 8'h00;
  int n_errors = 0;
  int n_checks = 0;

  always #12.5 clk_in = ~clk_in;

  fsrb_top #(.MODEL_REV_ID(REV), .OL_FILT_CYCLES(FILT)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .mosi_in(mosi),
    .select_bar_pin_in(select_bar_pin), .miso_out(miso), .miso_oe_n_out(miso_oe_n),
    .open_load_cmp_in(ol_cmp), .over_current_in(oc), .drv_off_cmd_in(off_cmd),
    .pd_dis_cmd_in(pd_dis), .sleep_in(sleep), .pd_en_out(pd_en), .vrs_peak_in(peak),
    .vrs_clamp_p_in(clamp_p), .vrs_clamp_n_in(clamp_n), .iso_over_temp_in(iso_ot),
    .keysw_in(keysw), .pwren_in(pwren), .batsw_in(batsw), .vp_short_bat_in(1'b0),
    .vp_over_temp_in(1'b0), .vp_short_gnd_in(vp_gnd), .wd_enable_in(wd_en),
    .wd_timer_in(wd_tmr), .on_off_in(on_off)
  );

  fsrb_host_model host (
    .clk_in(clk_in), .sclk_out(sclk), .mosi_out(mosi), .select_bar_out(select_bar_pin), .miso_in(miso)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : idle

  // Response arrives in the following frame
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [15:0] r;
    host.xfer({4'h0, a, 8'h00}, 16, r);
    host.xfer(16'h0f00, 16, r);
    chk({8'h00, r[7:0]}, {8'h00, e});
  endtask : rd_chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({4'h8, a, d}, 16, r);
  endtask : wr

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    chk({13'h0, pd_en}, 16'h0007);
    for (int a = 7; a <= 9; a++) rd_chk(a[3:0], 8'h00);
    rd_chk(4'hc, 8'h00);
    rd_chk(4'hf, REV);
  endtask : t_reset_vals

  task automatic t_oc_sticky();
    oc = 3'h2;
    idle(6);
    rd_chk(4'h8, 8'h84);
    wr(4'h8, 8'h00);
    rd_chk(4'h8, 8'h84);
    oc = 3'h0;
    wr(4'h8, 8'hff);
    rd_chk(4'h8, 8'h84);
    wr(4'h8, 8'h00);
    rd_chk(4'h8, 8'h00);
  endtask : t_oc_sticky

  task automatic t_open_load();
    off_cmd = 3'h5;
    idle(FILT + 50);
    // Select release must restart an already expired filter
    wr(4'hc, 8'hff);
    ol_cmp = 3'h7;
    idle(FILT / 2);
    ol_cmp = 3'h0;
    rd_chk(4'h7, 8'h00);
    idle(FILT + 50);
    ol_cmp = 3'h7;
    idle(10);
    ol_cmp = 3'h0;
    rd_chk(4'h7, 8'h88);
    rd_chk(4'h8, 8'h00);
    pd_dis = 3'h4;
    idle(2);
    chk({13'h0, pd_en}, 16'h0003);
    // Open-load bit reads zero, the summary stays until cleared
    rd_chk(4'h9, 8'h80);
    wr(4'h7, 8'h00);
    rd_chk(4'h7, 8'h00);
    pd_dis = 3'h0;
    sleep = 1'b1;
    idle(2);
    chk({13'h0, pd_en}, 16'h0000);
    sleep = 1'b0;
    off_cmd = 3'h0;
  endtask : t_open_load

  task automatic t_live_status();
    logic [15:0] r;
    peak = 4'ha;
    clamp_p = 1'b1;
    iso_ot = 1'b1;
    clamp_n = 1'b1;
    keysw = 1'b1;
    pwren = 1'b1;
    batsw = 1'b1;
    vp_gnd = 1'b1;
    wd_en = 1'b1;
    wd_tmr = 7'h35;
    on_off = 8'hc3;
    idle(6);
    iso_ot = 1'b0;
    vp_gnd = 1'b0;
    rd_chk(4'ha, 8'hb5);
    rd_chk(4'hb, 8'ha7);
    rd_chk(4'he, 8'hc3);
    rd_chk(4'hd, 8'hf1);
    host.xfer(16'h0d00, 15, r);
    rd_chk(4'hd, 8'hf9);
    peak = 4'h0;
    clamp_p = 1'b0;
    clamp_n = 1'b0;
    keysw = 1'b0;
    pwren = 1'b0;
    batsw = 1'b0;
    wr(4'hd, 8'h00);
    rd_chk(4'hd, 8'h00);
  endtask : t_live_status

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Whole run needs about 7500 cycles
  initial begin
    #1_000_000;
    n_errors++;
    end_of_test();
  end

  initial begin
    // Synchronisers need three edges under reset
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    idle(4);
    t_reset_vals();
    t_oc_sticky();
    t_open_load();
    t_live_status();
    end_of_test();
  end
endmodule : fsrb_top_bench

/* File: fsrb_top_chk.sv */
// Pin-level checker of the fault status register bank
`timescale 1ns/1ps
module fsrb_top_chk #(
  parameter int OL_FILT_CYCLES = fsrb_pkg::OL_FILT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Serial pins
  input wire logic sclk_in,
  input wire logic select_bar_pin_in,
  input wire logic miso_out,
  input wire logic miso_oe_n_out,
  // Pull-down control
  input wire logic [fsrb_pkg::N_DRV-1:0] pd_dis_cmd_in,
  input wire logic sleep_in,
  input wire logic [fsrb_pkg::N_DRV-1:0] pd_en_out
);
  import fsrb_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  //////////////////////////////////////////////////////////////////////////////
  AST_PD_RESET: assert property ($fell(sys_rst_in) |-> pd_en_out == PD_EN_RESET)
    else $error("pull-down not enabled after reset");
  AST_PD_FOLLOW: assert property (!$past(sys_rst_in) |->
    pd_en_out == ~($past(pd_dis_cmd_in) | {N_DRV{$past(sleep_in)}}))
    else $error("pull-down enable does not follow its commands");
  AST_PD_SLEEP: assert property (sleep_in |=> pd_en_out == 3'h0)
    else $error("pull-down left on in sleep");
  AST_PD_DROP: assert property (!sleep_in && !pd_dis_cmd_in[2] ##1
    pd_dis_cmd_in[2] && !sleep_in |=> $fell(pd_en_out[2]))
    else $error("pull-down did not drop on serial disable");
  AST_PD_BACK: assert property ($fell(sleep_in) && pd_dis_cmd_in == 3'h0 |=>
    pd_en_out == PD_EN_RESET)
    else $error("pull-down not restored after sleep");
  // Idle select must release the data line so other slaves can drive it
  AST_OE_IDLE: assert property (select_bar_pin_in [*5] |-> miso_oe_n_out)
    else $error("data line driven while deselected");
  AST_OE_ACT: assert property (!select_bar_pin_in [*5] |-> !miso_oe_n_out)
    else $error("data line not driven in a frame");
  AST_MISO_HOLD: assert property (sclk_in [*5] |-> $stable(miso_out))
    else $error("response bit changed while serial clock high");

  COV_FRAME: cover property (!miso_oe_n_out);
  COV_SLEEP: cover property ($rose(sleep_in));
  COV_PD_DIS: cover property ($rose(pd_dis_cmd_in[2]));
endmodule : fsrb_top_chk

bind fsrb_top fsrb_top_chk #(.OL_FILT_CYCLES(OL_FILT_CYCLES)) u_chk (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .sclk_in(sclk_in),
  .select_bar_pin_in(select_bar_pin_in),
  .miso_out(miso_out),
  .miso_oe_n_out(miso_oe_n_out),
  .pd_dis_cmd_in(pd_dis_cmd_in),
  .sleep_in(sleep_in),
  .pd_en_out(pd_en_out)
);
